// ### shared/plldc_defines.svh
// register offsets, field positions and reset values of the loop divider block
// assumes an 8-bit register port with 7-bit byte addresses from the control port
// Notes on behaviour
// R1: reference output follows loop enable when enabled
// R2: reference output enable resets to one
// R3: second divider codes give 1, 2, 4
// R4: first divider codes give 5, 4, 3
// R5: third divider 1..63, resets to 32
// R6: software holds loop reset before divider changes
// R7: software writes bias 0x4a, reset 0x4f
// R8: one pre-emphasis level for all lanes
// R9: software writes reserved fields as reset value
// R10: divider changes apply on loop reset release
`ifndef PLLDC_DEFINES_SVH
`define PLLDC_DEFINES_SVH
`define PLLDC_ADDR_REFO     7'h3c
`define PLLDC_ADDR_FBDIV12  7'h3d
`define PLLDC_ADDR_FBDIV3   7'h3e
`define PLLDC_ADDR_BIAS     7'h3f
`define PLLDC_ADDR_PE       7'h48
`define PLLDC_RST_REFO      8'h01
`define PLLDC_RST_FBDIV12   8'h00
`define PLLDC_RST_FBDIV3    8'h20
`define PLLDC_RST_BIAS      8'h4f
`define PLLDC_RST_PE        8'h00
`define PLLDC_REFO_EN_BIT   0
`define PLLDC_SECOND_MSB    3
`define PLLDC_SECOND_LSB    2
`define PLLDC_FIRST_MSB     1
`define PLLDC_FIRST_LSB     0
`define PLLDC_THIRD_MSB     5
`define PLLDC_BIAS_MSB      6
`define PLLDC_PE_MSB        3
`endif

// ### shared/plldc_pkg.sv
// types of the loop divider block
// assumes nothing outside
package plldc_pkg;
   typedef enum logic [1:0] {
      PLLDC_RUN     = 2'b00,
      PLLDC_HOLD    = 2'b01,
      PLLDC_RELEASE = 2'b10
   } plldc_state_t;
endpackage

// ### hdl/plldc_regs.sv
// register file and divider control for the sampling clock loop
// assumes writes arrive as a one-cycle strobe from the serial control port logic
`include "plldc_defines.svh"
module plldc_regs #(
   parameter int LANES = 8
) (
   // clock and reset
   input  wire logic              i_clk,
   input  wire logic              i_rst_n,
   // register port
   input  wire logic              i_wr_en,
   input  wire logic              i_rd_en,
   input  wire logic [6:0]        i_addr,
   input  wire logic [7:0]        i_wdata,
   output logic      [7:0]        o_rdata,
   output logic                   o_rdata_valid,
   // loop pins and controls
   input  wire logic              i_loop_enable,
   input  wire logic              i_loop_reset_control,
   output logic                   o_ref_clock_out_pins_en,
   output logic                   o_loop_reset,
   output logic                   o_relock_pulse,
   // applied dividers and settings
   output logic      [2:0]        o_second_div_ratio,
   output logic      [2:0]        o_first_div_ratio,
   output logic      [5:0]        o_third_div_ratio,
   output logic      [6:0]        o_oscillator_bias_field,
   output logic      [LANES*4-1:0] o_lane_preemphasis
);

   logic [7:0] refo_ff, fbdiv12_ff, fbdiv3_ff, bias_ff, pe_ff;
   logic [7:0] nxt_rdata;
   plldc_pkg::plldc_state_t state_ff, nxt_state;

   wire sel_refo    = i_addr == `PLLDC_ADDR_REFO;
   wire sel_fbdiv12 = i_addr == `PLLDC_ADDR_FBDIV12;
   wire sel_fbdiv3  = i_addr == `PLLDC_ADDR_FBDIV3;
   wire sel_bias    = i_addr == `PLLDC_ADDR_BIAS;
   wire sel_pe      = i_addr == `PLLDC_ADDR_PE;

   // reserved bits are stored as written; software keeps them at reset value
   // R2: enable bit resets set
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         refo_ff    <= `PLLDC_RST_REFO;
         fbdiv12_ff <= `PLLDC_RST_FBDIV12;
         fbdiv3_ff  <= `PLLDC_RST_FBDIV3;
         bias_ff    <= `PLLDC_RST_BIAS;
         pe_ff      <= `PLLDC_RST_PE;
      end else if (i_wr_en) begin
         if (sel_refo)    refo_ff    <= i_wdata;
         if (sel_fbdiv12) fbdiv12_ff <= i_wdata;
         if (sel_fbdiv3)  fbdiv3_ff  <= i_wdata;
         if (sel_bias)    bias_ff    <= i_wdata;
         if (sel_pe)      pe_ff      <= i_wdata;
      end
   end

   assign nxt_rdata = sel_refo    ? refo_ff    :
                      sel_fbdiv12 ? fbdiv12_ff :
                      sel_fbdiv3  ? fbdiv3_ff  :
                      sel_bias    ? bias_ff    :
                      sel_pe      ? pe_ff      : 8'h00;

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_rdata       <= 8'h00;
         o_rdata_valid <= 1'b0;
      end else begin
         o_rdata_valid <= i_rd_en;
         if (i_rd_en) o_rdata <= nxt_rdata;
      end
   end

   // R1: reference output gating
   wire nxt_ref_en = refo_ff[`PLLDC_REFO_EN_BIT] & i_loop_enable;

   // R3: second divider decode, reserved code holds divide-by-1
   wire [1:0] second_code = fbdiv12_ff[`PLLDC_SECOND_MSB:`PLLDC_SECOND_LSB];
   wire [2:0] second_dec  = (second_code == 2'h1) ? 3'h2 :
                            (second_code == 2'h2) ? 3'h4 : 3'h1;
   // R4: first divider decode, reserved code holds divide-by-5
   wire [1:0] first_code = fbdiv12_ff[`PLLDC_FIRST_MSB:`PLLDC_FIRST_LSB];
   wire [2:0] first_dec  = (first_code == 2'h1) ? 3'h4 :
                           (first_code == 2'h2) ? 3'h3 : 3'h5;
   // R5: zero is unsupported and keeps the previous ratio
   wire [5:0] third_code = fbdiv3_ff[`PLLDC_THIRD_MSB:0];

   // R10: sequencing of loop reset release
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         plldc_pkg::PLLDC_RUN: begin
            if (i_loop_reset_control) nxt_state = plldc_pkg::PLLDC_HOLD;
         end
         plldc_pkg::PLLDC_HOLD: begin
            if (!i_loop_reset_control) nxt_state = plldc_pkg::PLLDC_RELEASE;
         end
         // a reset raised in the apply cycle must not be lost, so it re-enters hold
         plldc_pkg::PLLDC_RELEASE: begin
            if (i_loop_reset_control) nxt_state = plldc_pkg::PLLDC_HOLD;
            else                      nxt_state = plldc_pkg::PLLDC_RUN;
         end
         default: begin
            nxt_state = plldc_pkg::PLLDC_RUN;
         end
      endcase
   end

   // dividers load only on release so a half-written set never reaches the loop
   wire load_div = (state_ff == plldc_pkg::PLLDC_RELEASE);

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_ff                <= plldc_pkg::PLLDC_RUN;
         o_ref_clock_out_pins_en <= 1'b0;
         o_loop_reset            <= 1'b0;
         o_relock_pulse          <= 1'b0;
         o_second_div_ratio      <= 3'h1;
         o_first_div_ratio       <= 3'h5;
         o_third_div_ratio       <= 6'h20;
      end else begin
         state_ff                <= nxt_state;
         o_ref_clock_out_pins_en <= nxt_ref_en;
         o_loop_reset            <= i_loop_reset_control;
         o_relock_pulse          <= load_div;
         if (load_div) begin
            o_second_div_ratio <= second_dec;
            o_first_div_ratio  <= first_dec;
            if (third_code != 6'h00) o_third_div_ratio <= third_code;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) o_oscillator_bias_field <= 7'h4f;
      else          o_oscillator_bias_field <= bias_ff[`PLLDC_BIAS_MSB:0];
   end

   // R8: one level fanned to every lane
   genvar g;
   generate
      for (g = 0; g < LANES; g++) begin : g_lane
         always_ff @(posedge i_clk or negedge i_rst_n) begin
            if (!i_rst_n) o_lane_preemphasis[g*4 +: 4] <= 4'h0;
            else          o_lane_preemphasis[g*4 +: 4] <= pe_ff[`PLLDC_PE_MSB:0];
         end
      end
   endgenerate

   // R1: output tracks enable and pin
   chk_ref_out_gate: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R1
      $past(i_rst_n) |-> o_ref_clock_out_pins_en == $past(refo_ff[0] & i_loop_enable))
      else $error("reference output not gated by enable");
   // R2: enabled after reset without writes
   chk_ref_reset_on: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R2
      $rose(i_rst_n) |-> refo_ff[0])
      else $error("reference enable not set after reset");

   // R10: reset held then dropped
   sequence s_release;
      i_loop_reset_control ##1 !i_loop_reset_control;
   endsequence
   // R10: pulse and new ratios together
   sequence s_applied;
      o_relock_pulse && o_first_div_ratio == $past(first_dec)
         && o_second_div_ratio == $past(second_dec);
   endsequence
   // R10: reset seen high then low
   sequence s_release_seen;
      $past(i_loop_reset_control, 3) && !$past(i_loop_reset_control, 2);
   endsequence
   // R10: dividers applied two cycles after release
   chk_div_apply: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R10
      s_release |-> ##2 s_applied)
      else $error("dividers not applied on release");
   // R10: relock only after a release
   chk_relock_cause: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R10
      o_relock_pulse |-> s_release_seen)
      else $error("relock pulse without a release");
   // R10: relock pulse lasts one cycle
   chk_relock_single: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R10
      o_relock_pulse |=> !o_relock_pulse)
      else $error("relock pulse longer than one cycle");
   // R10: ratios frozen while no release
   chk_div_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R10
      !$past(load_div) |-> $stable(o_third_div_ratio) && $stable(o_second_div_ratio)
         && $stable(o_first_div_ratio))
      else $error("divider changed outside release");
   // R10: loop reset follows its control
   chk_loop_reset_copy: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R10
      $past(i_rst_n) |-> o_loop_reset == $past(i_loop_reset_control))
      else $error("loop reset does not follow its control");

   // R3: second ratio is a power of two
   chk_second_map: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R3
      o_second_div_ratio inside {3'h1, 3'h2, 3'h4})
      else $error("second divider ratio illegal");
   // R4: first ratio stays in range
   chk_first_map: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R4
      o_first_div_ratio inside {3'h3, 3'h4, 3'h5})
      else $error("first divider ratio illegal");
   // R5: third ratio never zero
   chk_third_range: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R5
      o_third_div_ratio != 6'h00)
      else $error("third divider ratio zero");
   // R5: zero code keeps the old ratio
   chk_third_zero_keep: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R5
      (load_div && (third_code == 6'h00)) |=> $stable(o_third_div_ratio))
      else $error("zero third code changed the ratio");
   // R8: lanes agree
   chk_lanes_equal: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R8
      o_lane_preemphasis == {LANES{o_lane_preemphasis[3:0]}})
      else $error("lane pre-emphasis levels differ");

   // read data valid exactly one cycle after a read
   chk_rdata_valid: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      $past(i_rst_n) |-> o_rdata_valid == $past(i_rd_en))
      else $error("read data valid not one cycle after read");
   // read data stands until the next read
   chk_rdata_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      !$past(i_rd_en) |-> $stable(o_rdata))
      else $error("read data changed without a read");
   // bias output follows its register
   chk_bias_follow: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      o_oscillator_bias_field == $past(bias_ff[`PLLDC_BIAS_MSB:0]))
      else $error("bias output does not follow its register");

endmodule

// ### verification/test_plldc_regs.sv
// bench for the loop divider register block, driving the plain strobe port
// assumes the block alone on one 50 MHz clock, no serial framing in front
`include "plldc_defines.svh"
module test_plldc_regs;
   timeunit 1ns;
   timeprecision 1ps;
   logic        i_clk = 1'b0, i_rst_n = 1'b0, i_wr_en = 1'b0, i_rd_en = 1'b0;
   logic        i_loop_enable = 1'b0, i_loop_reset_control = 1'b0;
   logic [6:0]  i_addr = 7'h00;
   logic [7:0]  i_wdata = 8'h00, o_rdata;
   logic        o_rdata_valid, o_ref_clock_out_pins_en, o_loop_reset, o_relock_pulse;
   logic        seen;
   logic [2:0]  o_second_div_ratio, o_first_div_ratio;
   logic [5:0]  o_third_div_ratio;
   logic [6:0]  o_oscillator_bias_field;
   logic [31:0] o_lane_preemphasis;
   int          n_mismatch = 0, n_checks = 0, cyc = 0;
   plldc_regs #(.LANES(8)) u_plldc_regs (
      .i_clk(i_clk), .i_rst_n(i_rst_n), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en),
      .i_addr(i_addr), .i_wdata(i_wdata), .o_rdata(o_rdata), .o_rdata_valid(o_rdata_valid),
      .i_loop_enable(i_loop_enable), .i_loop_reset_control(i_loop_reset_control),
      .o_ref_clock_out_pins_en(o_ref_clock_out_pins_en), .o_loop_reset(o_loop_reset),
      .o_relock_pulse(o_relock_pulse), .o_second_div_ratio(o_second_div_ratio),
      .o_first_div_ratio(o_first_div_ratio), .o_third_div_ratio(o_third_div_ratio),
      .o_oscillator_bias_field(o_oscillator_bias_field),
      .o_lane_preemphasis(o_lane_preemphasis));
   always #10 i_clk = ~i_clk;
   task automatic final_report;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // the run is about 100 cycles, so a hang is cut well before it matters
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 3000) begin
         n_mismatch++;
         final_report;
      end
   end
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(posedge i_clk);
      i_wr_en <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clk);
      i_wr_en <= 1'b0;
   endtask
   task automatic rd(input logic [6:0] a, input logic [7:0] exp);
      @(posedge i_clk);
      i_rd_en <= 1'b1;
      i_addr <= a;
      @(posedge i_clk);
      i_rd_en <= 1'b0;
      #1;
      cmp({o_rdata_valid, o_rdata}, {1'b1, exp});
   endtask
   // reserved bits are always written as zero, only the divider fields vary
   task automatic relock(input logic [7:0] d12, input logic [7:0] d3, input logic [11:0] exp);
      @(posedge i_clk);
      i_loop_reset_control <= 1'b1;
      wr(`PLLDC_ADDR_FBDIV12, d12);
      wr(`PLLDC_ADDR_FBDIV3, d3);
      #1;
      cmp(o_loop_reset, 1'b1);
      @(posedge i_clk);
      i_loop_reset_control <= 1'b0;
      seen = 1'b0;
      repeat (6) begin
         @(posedge i_clk);
         #1;
         if (o_relock_pulse === 1'b1) seen = 1'b1;
      end
      cmp({seen, o_second_div_ratio, o_first_div_ratio, o_third_div_ratio}, {1'b1, exp});
      cmp(o_loop_reset, 1'b0);
   endtask
   initial begin
      repeat (4) @(posedge i_clk);
      i_rst_n <= 1'b1;
      @(posedge i_clk);
      #1;
      cmp({o_second_div_ratio, o_first_div_ratio, o_third_div_ratio}, 12'h360);
      cmp(o_oscillator_bias_field, 7'h4f);
      rd(`PLLDC_ADDR_REFO, 8'h01);
      rd(`PLLDC_ADDR_FBDIV12, 8'h00);
      rd(`PLLDC_ADDR_FBDIV3, 8'h20);
      rd(`PLLDC_ADDR_BIAS, 8'h4f);
      rd(`PLLDC_ADDR_PE, 8'h00);
      rd(7'h40, 8'h00);
      @(posedge i_clk);
      i_loop_enable <= 1'b1;
      repeat (2) @(posedge i_clk);
      #1;
      cmp(o_ref_clock_out_pins_en, 1'b1);
      wr(`PLLDC_ADDR_REFO, 8'h00);
      repeat (2) @(posedge i_clk);
      #1;
      cmp(o_ref_clock_out_pins_en, 1'b0);
      wr(`PLLDC_ADDR_REFO, 8'h01);
      repeat (2) @(posedge i_clk);
      #1;
      cmp(o_ref_clock_out_pins_en, 1'b1);
      @(posedge i_clk);
      i_loop_enable <= 1'b0;
      repeat (2) @(posedge i_clk);
      #1;
      cmp(o_ref_clock_out_pins_en, 1'b0);
      relock(8'h00, 8'h01, {3'd1, 3'd5, 6'd1});
      relock(8'h05, 8'h3f, {3'd2, 3'd4, 6'd63});
      // reserved codes give the default ratios, a zero third code keeps the old one
      relock(8'h0f, 8'h00, {3'd1, 3'd5, 6'd63});
      relock(8'h0a, 8'h20, {3'd4, 3'd3, 6'd32});
      // a divider write with the loop running must wait for a later release
      wr(`PLLDC_ADDR_FBDIV12, 8'h05);
      repeat (4) @(posedge i_clk);
      #1;
      cmp({o_second_div_ratio, o_first_div_ratio, o_third_div_ratio}, 12'h8e0);
      rd(`PLLDC_ADDR_FBDIV12, 8'h05);
      wr(`PLLDC_ADDR_BIAS, 8'h4a);
      wr(`PLLDC_ADDR_PE, 8'h09);
      @(posedge i_clk);
      #1;
      cmp(o_oscillator_bias_field, 7'h4a);
      cmp(o_lane_preemphasis, {8{4'h9}});
      rd(`PLLDC_ADDR_PE, 8'h09);
      // a reset in mid-run brings the defaults back without any write
      wr(`PLLDC_ADDR_REFO, 8'h00);
      @(posedge i_clk);
      i_loop_enable <= 1'b1;
      i_rst_n <= 1'b0;
      repeat (2) @(posedge i_clk);
      i_rst_n <= 1'b1;
      repeat (2) @(posedge i_clk);
      #1;
      cmp(o_ref_clock_out_pins_en, 1'b1);
      cmp({o_second_div_ratio, o_first_div_ratio, o_third_div_ratio}, 12'h360);
      cmp(o_oscillator_bias_field, 7'h4f);
      cmp(o_lane_preemphasis, 32'h0);
      rd(`PLLDC_ADDR_REFO, 8'h01);
      final_report;
   end
endmodule
